// [rtl/dac_bus_host.sv]
// Host controller that loads and updates double-buffered 12-bit converters
// Notes on behaviour
// - Several enables may be asserted in one write; all enabled latches load.
// - Fill several converters' input latches, then strobe all converter latches together.
// - On an 8-bit bus each 12-bit code goes as two right-justified byte writes.
// - Base address from high bits; A0 and A1 select the individual enables.
// - Offset X10 asserts only the low-byte enable, storing eight low bits.
// - Offset X01 asserts high-nibble and converter enables, storing and transferring together.
// - Used offsets are adjacent; X00 and X11 stay unused.
// - Four converters use eight adjacent addresses, one per input latch.
// - A ninth address, bit A3, asserts the common converter enable on all devices.
// - Common converter enable may tie to the last device's low-byte enable.
// - On wide buses both input enables held low; converter latch strobed by write. Here both enables go low only during each write, for the selected converter.
// - Write strobe comes from device select combined with the processor write.
`timescale 1ns/1ns
module dac_bus_host #(
	parameter int NUM_DACS     = 4,
	parameter bit TIE_LAST_CONVERTER_LATCH_LOAD_N = 1'b0,
	parameter int DEV_W        = (NUM_DACS > 1) ? $clog2(NUM_DACS) : 1
) (
	// Clock, reset, enable
	input  wire logic                            CORE_CLK,
	input  wire logic                            RST_N,
	input  wire logic                            CE,
	// User command port
	input  wire logic                            CMD_VALID,
	input  wire logic [1:0]                      CMD_MODE,
	input  wire logic [DEV_W-1:0]                CMD_DEV,
	input  wire logic [dac_host_pkg::CODE_W-1:0] CMD_CODE,
	output logic                                 CMD_READY,
	output logic                                 CMD_DONE,
	input  wire logic                            RESET_REQ,
	// Converter pins
	output logic [dac_host_pkg::CODE_W-1:0]      DAC_DATA,
	output logic                                 DAC_WR_N,
	output logic [NUM_DACS-1:0]                  LOW_BYTE_LATCH_ENABLE_N,
	output logic [NUM_DACS-1:0]                  HIGH_NIBBLE_LATCH_ENABLE_N,
	output logic [NUM_DACS-1:0]                  CONVERTER_LATCH_LOAD_N,
	output logic                                 DAC_RESET_N
);

	localparam logic [DEV_W-1:0] LAST_DEV = DEV_W'(NUM_DACS - 1);

	typedef struct packed {
		logic [dac_host_pkg::CODE_W-1:0] data;
		logic [NUM_DACS-1:0]             lsb_n;
		logic [NUM_DACS-1:0]             msb_n;
		logic [NUM_DACS-1:0]             converter_latch_load_n_n;
		logic                            last;
	} step_s;

	typedef struct packed {
		dac_host_pkg::host_state_e       state;
		dac_host_pkg::mode_e             mode;
		logic [DEV_W-1:0]                dev;
		logic [dac_host_pkg::CODE_W-1:0] code;
		logic                            step;
		logic                            last;
		logic                            req;
		logic [dac_host_pkg::CODE_W-1:0] data;
		logic [NUM_DACS-1:0]             lsb_n;
		logic [NUM_DACS-1:0]             msb_n;
		logic [NUM_DACS-1:0]             converter_latch_load_n_n;
		logic [dac_host_pkg::CNT_W-1:0]  rcnt;
		logic                            ready;
		logic                            done;
		logic                            rst_pin_n;
	} host_s;

	host_s st_reg;
	host_s st_next;
	step_s plan;

	dac_cycle_if #(.NUM_DACS(NUM_DACS)) cyc ();

	// One-hot active-low select of a converter
	function automatic logic [NUM_DACS-1:0] sel_n(input logic [DEV_W-1:0] dev);
		logic [NUM_DACS-1:0] v;
		v = '1;
		for (int i = 0; i < NUM_DACS; i++) begin
			if (DEV_W'(i) == dev) begin
				v[i] = 1'b0;
			end
		end
		return v;
	endfunction : sel_n

	// Address bits 1:0 of the 8-bit scheme to enables
	function automatic step_s offset_decode(input logic [1:0] ofs,
		input logic [DEV_W-1:0] dev, input logic [dac_host_pkg::CODE_W-1:0] code);
		step_s s;
		s.lsb_n  = '1;
		s.msb_n  = '1;
		s.converter_latch_load_n_n = '1;
		s.data   = dac_host_pkg::CODE_ZERO;
		s.last   = 1'b0;
		unique case (ofs)
			dac_host_pkg::OFS_LOW: begin
				s.lsb_n = sel_n(dev);
				s.data  = {{dac_host_pkg::NIB_W{1'b0}}, code[dac_host_pkg::BYTE_W-1:0]};
			end
			dac_host_pkg::OFS_HIGH: begin
				s.msb_n  = sel_n(dev);
				s.converter_latch_load_n_n = sel_n(dev);
				s.data   = {{dac_host_pkg::BYTE_W{1'b0}},
					code[dac_host_pkg::CODE_W-1:dac_host_pkg::NIB_LO]};
				s.last   = 1'b1;
			end
			dac_host_pkg::OFS_UNUSED_LO, dac_host_pkg::OFS_UNUSED_HI: begin
				s.last = 1'b1;
			end
		endcase
		return s;
	endfunction : offset_decode

	// Pin pattern of one write for a mode and step
	// Kept a function: a process of its own would loop with the sequencer
	function automatic step_s write_plan(input dac_host_pkg::mode_e mode,
		input logic [DEV_W-1:0] dev, input logic [dac_host_pkg::CODE_W-1:0] code,
		input logic step);
		step_s lo;
		step_s hi;
		step_s p;
		lo = offset_decode(dac_host_pkg::OFS_LOW, dev, code);
		hi = offset_decode(dac_host_pkg::OFS_HIGH, dev, code);
		p  = lo;
		unique case (mode)
			dac_host_pkg::MODE_SINGLE: begin
				// Low byte first, then nibble plus transfer in one write
				p = step ? hi : lo;
			end
			dac_host_pkg::MODE_STAGE: begin
				if (TIE_LAST_CONVERTER_LATCH_LOAD_N && dev == LAST_DEV) begin
					// Nibble first; the last low byte also fires every converter latch
					if (step) begin
						p.converter_latch_load_n_n = '0;
						p.last   = 1'b1;
					end else begin
						p        = hi;
						p.converter_latch_load_n_n = '1;
						p.last   = 1'b0;
					end
				end else begin
					// Input latches only; outputs wait for the common update
					p        = step ? hi : lo;
					p.converter_latch_load_n_n = '1;
				end
			end
			dac_host_pkg::MODE_UPDATE: begin
				// Every converter latch loads in the same write
				p.data   = code;
				p.lsb_n  = '1;
				p.msb_n  = '1;
				p.converter_latch_load_n_n = '0;
				p.last   = 1'b1;
			end
			dac_host_pkg::MODE_WIDE: begin
				// Input latches transparent, converter latch strobed by write
				p.data   = code;
				p.lsb_n  = sel_n(dev);
				p.msb_n  = sel_n(dev);
				p.converter_latch_load_n_n = sel_n(dev);
				p.last   = 1'b1;
			end
		endcase
		return p;
	endfunction : write_plan

	// Command sequencing
	always_comb begin
		st_next      = st_reg;
		st_next.req  = 1'b0;
		st_next.done = 1'b0;
		unique case (st_reg.state)
			dac_host_pkg::ST_IDLE: begin
				// Converter reset pin released while idle, also after a core reset
				st_next.rst_pin_n = 1'b1;
				if (RESET_REQ) begin
					st_next.rst_pin_n = 1'b0;
					st_next.rcnt      = dac_host_pkg::RESET_CNT;
					st_next.ready     = 1'b0;
					st_next.state     = dac_host_pkg::ST_RESET;
				end else if (CMD_VALID && st_reg.ready) begin
					st_next.mode  = dac_host_pkg::mode_e'(CMD_MODE);
					st_next.dev   = CMD_DEV;
					st_next.code  = CMD_CODE;
					st_next.step  = 1'b0;
					st_next.ready = 1'b0;
					st_next.req   = 1'b1;
					st_next.state = dac_host_pkg::ST_WAIT;
				end
			end
			dac_host_pkg::ST_WAIT: begin
				if (cyc.done) begin
					if (st_reg.last) begin
						st_next.ready = 1'b1;
						st_next.done  = 1'b1;
						st_next.state = dac_host_pkg::ST_IDLE;
					end else begin
						st_next.step = 1'b1;
						st_next.req  = 1'b1;
					end
				end
			end
			dac_host_pkg::ST_RESET: begin
				if (st_reg.rcnt == dac_host_pkg::CNT_ZERO) begin
					st_next.rst_pin_n = 1'b1;
					st_next.ready     = 1'b1;
					st_next.state     = dac_host_pkg::ST_IDLE;
				end else begin
					st_next.rcnt = st_reg.rcnt - 1'b1;
				end
			end
			default: begin
				st_next.state = dac_host_pkg::ST_IDLE;
			end
		endcase
		// Pattern follows the next mode and step, so the second write of a pair is right
		plan = write_plan(st_next.mode, st_next.dev, st_next.code, st_next.step);
		if (st_next.req) begin
			st_next.data   = plan.data;
			st_next.lsb_n  = plan.lsb_n;
			st_next.msb_n  = plan.msb_n;
			st_next.converter_latch_load_n_n = plan.converter_latch_load_n_n;
			st_next.last   = plan.last;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_reg.state     <= dac_host_pkg::ST_IDLE;
			st_reg.mode      <= dac_host_pkg::MODE_SINGLE;
			st_reg.dev       <= '0;
			st_reg.code      <= dac_host_pkg::CODE_ZERO;
			st_reg.step      <= 1'b0;
			st_reg.last      <= 1'b0;
			st_reg.req       <= 1'b0;
			st_reg.data      <= dac_host_pkg::CODE_ZERO;
			st_reg.lsb_n     <= '1;
			st_reg.msb_n     <= '1;
			st_reg.converter_latch_load_n_n    <= '1;
			st_reg.rcnt      <= dac_host_pkg::CNT_ZERO;
			st_reg.ready     <= 1'b1;
			st_reg.done      <= 1'b0;
			st_reg.rst_pin_n <= 1'b0;
		end else if (CE) begin
			st_reg <= st_next;
		end
	end

	// Write request to the strobe timer
	assign cyc.req    = st_reg.req;
	assign cyc.data   = st_reg.data;
	assign cyc.lsb_n  = st_reg.lsb_n;
	assign cyc.msb_n  = st_reg.msb_n;
	assign cyc.converter_latch_load_n_n = st_reg.converter_latch_load_n_n;

	dac_strobe_timer #(.NUM_DACS(NUM_DACS)) timer (
		.clk    (CORE_CLK),
		.rst_n  (RST_N),
		.ce     (CE),
		.cyc    (cyc.seq),
		.wr_n   (DAC_WR_N),
		.data   (DAC_DATA),
		.lsb_n  (LOW_BYTE_LATCH_ENABLE_N),
		.msb_n  (HIGH_NIBBLE_LATCH_ENABLE_N),
		.converter_latch_load_n_n (CONVERTER_LATCH_LOAD_N)
	);

	// Handshake and converter reset pin
	assign CMD_READY   = st_reg.ready;
	assign CMD_DONE    = st_reg.done;
	assign DAC_RESET_N = st_reg.rst_pin_n;

endmodule : dac_bus_host

// [rtl/dac_host_pkg.sv]
// Constants and types shared by the converter bus host and its strobe timer
package dac_host_pkg;

	// Clock and pin timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SETUP_NS    = 50;
	localparam int T_STROBE_NS   = 100;
	localparam int T_HOLD_NS     = 50;
	localparam int T_RESET_NS    = 1000;

	// Least times round up to whole cycles, never below one
	localparam int SETUP_CYC  = ((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int STROBE_CYC = ((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int HOLD_CYC   = ((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int RESET_CYC  = ((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Cycle counters
	localparam int             CNT_W      = 8;
	localparam logic [CNT_W-1:0] SETUP_CNT  = CNT_W'(SETUP_CYC - 1);
	localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_CNT   = CNT_W'(HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] RESET_CNT  = CNT_W'(RESET_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;

	// Data layout
	localparam int CODE_W = 12;
	localparam int BYTE_W = 8;
	localparam int NIB_W  = 4;
	localparam int NIB_LO = 8;
	localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;

	// Offsets of the right-justified 8-bit scheme, address bits 1:0
	localparam logic [1:0] OFS_UNUSED_LO = 2'h0;
	localparam logic [1:0] OFS_HIGH      = 2'h1;
	localparam logic [1:0] OFS_LOW       = 2'h2;
	localparam logic [1:0] OFS_UNUSED_HI = 2'h3;

	// Command modes
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'h0,
		MODE_STAGE  = 2'h1,
		MODE_UPDATE = 2'h2,
		MODE_WIDE   = 2'h3
	} mode_e;

	// Strobe timer phases
	typedef enum logic [1:0] {
		PH_IDLE   = 2'h0,
		PH_SETUP  = 2'h1,
		PH_STROBE = 2'h2,
		PH_HOLD   = 2'h3
	} phase_e;

	// Host sequencer states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_WAIT  = 2'h1,
		ST_RESET = 2'h2
	} host_state_e;

endpackage : dac_host_pkg

// [rtl/dac_cycle_if.sv]
// Carrier between the host sequencer and the strobe timer
`timescale 1ns/1ns
interface dac_cycle_if #(
	parameter int NUM_DACS = 4
);
	logic                              req;
	logic                              done;
	logic [dac_host_pkg::CODE_W-1:0]   data;
	logic [NUM_DACS-1:0]               lsb_n;
	logic [NUM_DACS-1:0]               msb_n;
	logic [NUM_DACS-1:0]               converter_latch_load_n_n;

	modport ctrl (
		output req,
		output data,
		output lsb_n,
		output msb_n,
		output converter_latch_load_n_n,
		input  done
	);

	modport seq (
		input  req,
		input  data,
		input  lsb_n,
		input  msb_n,
		input  converter_latch_load_n_n,
		output done
	);
endinterface : dac_cycle_if

// [rtl/dac_strobe_timer.sv]
// One write cycle on the converter pins: setup, write strobe, hold
`timescale 1ns/1ns
module dac_strobe_timer #(
	parameter int NUM_DACS = 4
) (
	// Clock, reset, enable
	input  wire logic                            clk,
	input  wire logic                            rst_n,
	input  wire logic                            ce,
	// Cycle request
	dac_cycle_if.seq                             cyc,
	// Converter pins
	output logic                                 wr_n,
	output logic [dac_host_pkg::CODE_W-1:0]      data,
	output logic [NUM_DACS-1:0]                  lsb_n,
	output logic [NUM_DACS-1:0]                  msb_n,
	output logic [NUM_DACS-1:0]                  converter_latch_load_n_n
);

	typedef struct packed {
		dac_host_pkg::phase_e                phase;
		logic [dac_host_pkg::CNT_W-1:0]      cnt;
		logic                                wr_n;
		logic [dac_host_pkg::CODE_W-1:0]     data;
		logic [NUM_DACS-1:0]                 lsb_n;
		logic [NUM_DACS-1:0]                 msb_n;
		logic [NUM_DACS-1:0]                 converter_latch_load_n_n;
		logic                                done;
	} timer_s;

	timer_s st_reg;
	timer_s st_next;

	always_comb begin
		st_next      = st_reg;
		st_next.done = 1'b0;
		unique case (st_reg.phase)
			dac_host_pkg::PH_IDLE: begin
				if (cyc.req) begin
					// Enables and data settle while the strobe is still high
					st_next.data   = cyc.data;
					st_next.lsb_n  = cyc.lsb_n;
					st_next.msb_n  = cyc.msb_n;
					st_next.converter_latch_load_n_n = cyc.converter_latch_load_n_n;
					st_next.cnt    = dac_host_pkg::SETUP_CNT;
					st_next.phase  = dac_host_pkg::PH_SETUP;
				end
			end
			dac_host_pkg::PH_SETUP: begin
				if (st_reg.cnt == dac_host_pkg::CNT_ZERO) begin
					st_next.wr_n  = 1'b0;
					st_next.cnt   = dac_host_pkg::STROBE_CNT;
					st_next.phase = dac_host_pkg::PH_STROBE;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
			dac_host_pkg::PH_STROBE: begin
				if (st_reg.cnt == dac_host_pkg::CNT_ZERO) begin
					// Strobe rises first so the latches close on the fast path
					st_next.wr_n  = 1'b1;
					st_next.cnt   = dac_host_pkg::HOLD_CNT;
					st_next.phase = dac_host_pkg::PH_HOLD;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
			dac_host_pkg::PH_HOLD: begin
				if (st_reg.cnt == dac_host_pkg::CNT_ZERO) begin
					st_next.lsb_n  = '1;
					st_next.msb_n  = '1;
					st_next.converter_latch_load_n_n = '1;
					st_next.done   = 1'b1;
					st_next.phase  = dac_host_pkg::PH_IDLE;
				end else begin
					st_next.cnt = st_reg.cnt - 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg.phase  <= dac_host_pkg::PH_IDLE;
			st_reg.cnt    <= dac_host_pkg::CNT_ZERO;
			st_reg.wr_n   <= 1'b1;
			st_reg.data   <= dac_host_pkg::CODE_ZERO;
			st_reg.lsb_n  <= '1;
			st_reg.msb_n  <= '1;
			st_reg.converter_latch_load_n_n <= '1;
			st_reg.done   <= 1'b0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign cyc.done = st_reg.done;
	assign wr_n     = st_reg.wr_n;
	assign data     = st_reg.data;
	assign lsb_n    = st_reg.lsb_n;
	assign msb_n    = st_reg.msb_n;
	assign converter_latch_load_n_n   = st_reg.converter_latch_load_n_n;

endmodule : dac_strobe_timer

// [tb/dac_latch_model.sv]
// Behavioural model of the double-buffered converter latches
`timescale 1ns/1ns
module dac_latch_model #(
	parameter int NUM_DACS = 4
) (
	// Converter pins
	input  wire logic [11:0]                data,
	input  wire logic                       wr_n,
	input  wire logic [NUM_DACS-1:0]        low_n,
	input  wire logic [NUM_DACS-1:0]        high_n,
	input  wire logic [NUM_DACS-1:0]        load_n,
	input  wire logic                       reset_n,
	// Held converter codes
	output logic      [NUM_DACS-1:0][11:0]  code
);
	logic [NUM_DACS-1:0][3:0] nib;
	logic [NUM_DACS-1:0][7:0] lsb;

	// Level latches; byte-wide wiring folds the nibble onto data 3:0
	always @* begin
		for (int d = 0; d < NUM_DACS; d++) begin
			if (!wr_n && !high_n[d]) begin
				nib[d] = !low_n[d] ? data[11:8] : data[3:0];
			end
			if (!wr_n && !low_n[d]) begin
				lsb[d] = data[7:0];
			end
			if (!reset_n) begin
				code[d] = 12'h800;
			end else if (!wr_n && !load_n[d]) begin
				code[d] = {nib[d], lsb[d]};
			end
		end
	end
endmodule : dac_latch_model

// [tb/dac_bus_host_sva.sv]
// Checker of the converter bus host pin and handshake timing
`timescale 1ns/1ns
module dac_bus_host_chk #(
	parameter int NUM_DACS = 4,
	parameter int DEV_W    = 2
) (
	input wire logic                CORE_CLK,
	input wire logic                RST_N,
	input wire logic                CE,
	input wire logic                CMD_VALID,
	input wire logic [1:0]          CMD_MODE,
	input wire logic [DEV_W-1:0]    CMD_DEV,
	input wire logic [11:0]         CMD_CODE,
	input wire logic                CMD_READY,
	input wire logic                CMD_DONE,
	input wire logic                RESET_REQ,
	input wire logic [11:0]         DAC_DATA,
	input wire logic                DAC_WR_N,
	input wire logic [NUM_DACS-1:0] LOW_BYTE_LATCH_ENABLE_N,
	input wire logic [NUM_DACS-1:0] HIGH_NIBBLE_LATCH_ENABLE_N,
	input wire logic [NUM_DACS-1:0] CONVERTER_LATCH_LOAD_N,
	input wire logic                DAC_RESET_N
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	logic [NUM_DACS-1:0] lo, hi, ld;
	logic                wr, take;
	assign lo = LOW_BYTE_LATCH_ENABLE_N;
	assign hi = HIGH_NIBBLE_LATCH_ENABLE_N;
	assign ld = CONVERTER_LATCH_LOAD_N;
	assign wr = !DAC_WR_N;
	assign take = CE && CMD_VALID && CMD_READY && !RESET_REQ;

	chk_strobe_pulse: assert property (
		$fell(DAC_WR_N) |=> DAC_WR_N) else $error("write strobe too wide");
	chk_low_only: assert property (
		wr && !(&lo) && &hi |-> &ld && DAC_DATA[11:8] == 4'h0) else $error("low byte write bad");
	chk_nibble_load: assert property (
		wr && !(&hi) && &lo |-> (ld == hi || &ld) && DAC_DATA[11:4] == 8'h00)
		else $error("nibble write bad");
	chk_one_device: assert property (
		wr |-> $onehot0(~lo) && $onehot0(~hi)) else $error("several devices selected");
	chk_common_update: assert property (
		wr && &lo && &hi && !(&ld) |-> ld == '0) else $error("update not common");
	chk_wide_open: assert property (
		wr && !(&lo) && !(&hi) |-> lo == hi && ld == lo) else $error("wide write bad");
	chk_setup_hold: assert property (
		$fell(DAC_WR_N) || $rose(DAC_WR_N) |-> $stable(lo) && $stable(hi) && $stable(ld)
		&& $stable(DAC_DATA)) else $error("pins move at strobe edge");
	chk_one_write: assert property (
		take && CMD_MODE[1] |-> ##3 wr ##3 CMD_DONE) else $error("single write timing");
	chk_two_writes: assert property (
		take && !CMD_MODE[1] |-> ##3 wr ##5 wr ##3 CMD_DONE) else $error("byte pair timing");
	chk_reset_pulse: assert property (
		RESET_REQ && CMD_READY && CE && DAC_RESET_N |-> ##1 !DAC_RESET_N ##9 !DAC_RESET_N
		##1 DAC_RESET_N) else $error("reset pulse length");
endmodule : dac_bus_host_chk

bind dac_bus_host dac_bus_host_chk #(.NUM_DACS(NUM_DACS), .DEV_W(DEV_W)) dac_bus_host_chk_i (
	.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD_MODE(CMD_MODE),
	.CMD_DEV(CMD_DEV), .CMD_CODE(CMD_CODE), .CMD_READY(CMD_READY), .CMD_DONE(CMD_DONE),
	.RESET_REQ(RESET_REQ), .DAC_DATA(DAC_DATA), .DAC_WR_N(DAC_WR_N),
	.LOW_BYTE_LATCH_ENABLE_N(LOW_BYTE_LATCH_ENABLE_N),
	.HIGH_NIBBLE_LATCH_ENABLE_N(HIGH_NIBBLE_LATCH_ENABLE_N),
	.CONVERTER_LATCH_LOAD_N(CONVERTER_LATCH_LOAD_N), .DAC_RESET_N(DAC_RESET_N));

// [tb/tb_dac_bus_host.sv]
// Testbench of the converter bus host with a latch model
`timescale 1ns/1ns
module tb_dac_bus_host;
	logic             clk = 1'b0;
	logic             rst_n = 1'b0;
	logic             ce = 1'b1;
	logic             cmd_valid = 1'b0;
	logic [1:0]       cmd_mode = 2'h0;
	logic [1:0]       cmd_dev = 2'h0;
	logic [11:0]      cmd_code = 12'h000;
	logic             reset_req = 1'b0;
	logic             cmd_ready, cmd_done, dac_wr_n, dac_reset_n;
	logic [11:0]      dac_data;
	logic [3:0]       low_n, high_n, load_n;
	logic [3:0][11:0] code, exp;
	int               miscompares = 0;
	int               tests_run = 0;
	int               cycles = 0;

	always #50 clk = ~clk;

	dac_bus_host dac_bus_host_i (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .CMD_VALID(cmd_valid),
		.CMD_MODE(cmd_mode), .CMD_DEV(cmd_dev), .CMD_CODE(cmd_code), .CMD_READY(cmd_ready),
		.CMD_DONE(cmd_done), .RESET_REQ(reset_req), .DAC_DATA(dac_data), .DAC_WR_N(dac_wr_n),
		.LOW_BYTE_LATCH_ENABLE_N(low_n), .HIGH_NIBBLE_LATCH_ENABLE_N(high_n),
		.CONVERTER_LATCH_LOAD_N(load_n), .DAC_RESET_N(dac_reset_n));

	dac_latch_model #(.NUM_DACS(4)) dac_latch_model_i (.data(dac_data), .wr_n(dac_wr_n),
		.low_n(low_n), .high_n(high_n), .load_n(load_n), .reset_n(dac_reset_n), .code(code));

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] want);
		tests_run++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic codes_ok();
		for (int d = 0; d < 4; d++)
			check("code", code[d], exp[d]);
	endtask : codes_ok

	task automatic wait_done(input int want);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (cmd_done !== 1'b1 && n < 30);
		check("done cycles", 12'(n), 12'(want));
	endtask : wait_done

	task automatic issue(input logic [1:0] m, input logic [1:0] d, input logic [11:0] c);
		@(posedge clk);
		cmd_mode <= m;
		cmd_dev <= d;
		cmd_code <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_done(m[1] ? 6 : 11);
	endtask : issue

	task automatic t_reset();
		@(negedge clk);
		check("wr_n", 12'(dac_wr_n), 12'h001);
		check("enables", 12'({low_n, high_n, load_n}), 12'hfff);
		exp = {4{12'h800}};
		codes_ok();
	endtask : t_reset

	task automatic t_single();
		issue(dac_host_pkg::MODE_SINGLE, 2'h1, 12'ha5c);
		exp[1] = 12'ha5c;
		codes_ok();
	endtask : t_single

	task automatic t_stage_update();
		for (int i = 0; i < 4; i++)
			issue(dac_host_pkg::MODE_STAGE, 2'(i), 12'h111 * 12'(i + 1));
		codes_ok();
		issue(dac_host_pkg::MODE_UPDATE, 2'h0, 12'hfff);
		for (int i = 0; i < 4; i++)
			exp[i] = 12'h111 * 12'(i + 1);
		codes_ok();
	endtask : t_stage_update

	task automatic t_wide();
		issue(dac_host_pkg::MODE_WIDE, 2'h2, 12'h9e7);
		exp[2] = 12'h9e7;
		codes_ok();
	endtask : t_wide

	task automatic t_refuse();
		@(posedge clk);
		cmd_mode <= dac_host_pkg::MODE_SINGLE;
		cmd_dev <= 2'h0;
		cmd_code <= 12'h0f0;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		@(posedge clk);
		cmd_dev <= 2'h3;
		cmd_code <= 12'h777;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		wait_done(9);
		exp[0] = 12'h0f0;
		codes_ok();
	endtask : t_refuse

	task automatic t_conv_reset();
		int n;
		@(posedge clk);
		cmd_mode <= dac_host_pkg::MODE_WIDE;
		cmd_code <= 12'h123;
		cmd_valid <= 1'b1;
		reset_req <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		reset_req <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((cmd_ready !== 1'b1 || dac_reset_n !== 1'b1) && n < 30);
		check("reset cycles", 12'(n), 12'h00b);
		exp = {4{12'h800}};
		codes_ok();
	endtask : t_conv_reset

	task automatic t_rst_mid();
		issue(dac_host_pkg::MODE_SINGLE, 2'h0, 12'h5a5);
		exp[0] = 12'h5a5;
		codes_ok();
		@(posedge clk);
		rst_n <= 1'b0;
		t_reset();
		@(posedge clk);
		rst_n <= 1'b1;
		t_single();
	endtask : t_rst_mid

	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_single();
		t_stage_update();
		t_wide();
		t_refuse();
		t_conv_reset();
		t_rst_mid();
		wrap_up();
	end
endmodule : tb_dac_bus_host
